// File: rtl/fbc_top.v
// Overview of operation
// R01: Lock off lets software change batch size and prewarn freely.
// R02: Lock on makes them read-only unless the setup path is unlocked.
// R03: Batch mode enables batching and disables both flow alarms.
// R04: Alarms work only with batch off; setpoints writable only with lock off. The code also writes them with lock on while setup_unlocked is high.
// R05: Each alarm closes when flow percent reaches its 0 to 99 setpoint.
// R06: Counting modes: forward only, separate forward and reverse, or net.
// R07: Units come from a list or user code with three characters; invalid codes ignored.
// R08: User units carry a gallons-per-unit factor that scales the totals. The code scales only the forward count, into scaled_total.
// R09: Preset loads grand total with batch on, count with batch off.
// R10: Batch count shown up or down; batch limit drives relay one, prewarn relay two.
// R11: Status digits 1 and 2 show while the matching relay is commanded on.
// R12: Reset re-arms the batch, enters ready and stops the alternating display.
// R13: Start in ready or stopped energizes both relays and starts counting. From stopped past prewarn, the code keeps relay two off.
// R14: Reaching prewarn drops relay two and enters the prewarn state.
// R15: Completion releases relays, enters hold and alternates the display.
// R16: Stop forces relays off, digits still show on, counting halts.
// R17: From stopped, start resumes the batch and reset abandons it.
// R18: Grand total takes all flow delivered into a batch, before a stop too.
// R19: Batch advances one per registration unit; done when count equals size.
//
// Our own choices: the address map and the APB register port.
`include "fbc_consts.vh"

module fbc_top #(
	parameter BW = 20,
	parameter TW = 30,
	parameter ALT_CYCLES = `FBC_ALT_TIME_MS * `FBC_CLK_KHZ
) (
	input wire clock,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire rearm_btn,
	input wire start_btn,
	input wire stop_btn,
	input wire flow_pulse,
	input wire flow_rev,
	input wire [6:0] flow_pct,
	input wire setup_unlocked,
	output wire relay1,
	output wire relay2,
	output wire alarm1,
	output wire alarm2,
	output reg disp_digit1,
	output reg disp_digit2,
	output reg disp_show_batch,
	output reg [4:0] disp_state,
	output reg [BW-1:0] disp_batch,
	output wire irq
);

	// ----------------------------------------
	// States.
	// ----------------------------------------
	localparam [4:0] ST_READY = 5'h01;
	localparam [4:0] ST_RUN = 5'h02;
	localparam [4:0] ST_PRE = 5'h04;
	localparam [4:0] ST_HOLD = 5'h08;
	localparam [4:0] ST_STOP = 5'h10;
	localparam [31:0] ALT_LAST = ALT_CYCLES - 1;

	reg edit_lock;
	reg batch_en;
	reg [1:0] count_mode;
	reg count_up;
	reg [BW-1:0] batch_size;
	reg [BW-1:0] prewarn_level;
	reg [6:0] alarm_sp1;
	reg [6:0] alarm_sp2;
	reg [3:0] total_units;
	reg [23:0] unit_abbr;
	reg [31:0] conv_factor;
	reg [TW-1:0] grand_total;
	reg [TW-1:0] forward_counter;
	reg [TW-1:0] reverse_counter;
	reg [TW-1:0] scaled_total;
	reg [BW-1:0] batch_cnt;
	reg [4:0] state;
	reg [4:0] next_state;
	reg relay1_cmd;
	reg relay2_cmd;
	reg [3:0] int_stat;
	reg [3:0] int_mask;
	reg [31:0] alt_cnt;
	reg alt_tick;
	reg [31:0] rd_mux;
	wire rearm_lvl;
	wire start_lvl;
	wire stop_lvl;
	wire rev_lvl;
	wire flow_lvl;
	wire rearm_ev;
	wire start_ev;
	wire stop_ev;
	wire flow_ev;
	wire wr_en;
	wire rd_setup;
	wire mapped;
	wire size_wr_ok;
	wire alarm_wr_ok;
	wire running;
	wire qualified;
	wire prewarn_hit;
	wire done_hit;
	wire [3:0] events;
	wire [61:0] scale_prod;

	// ----------------------------------------
	// Push and flow inputs from outside the clock domain.
	// ----------------------------------------
	fbc_sync u_sync_rearm (.clock(clock), .srst(srst), .din(rearm_btn), .dout(rearm_lvl), .rise(rearm_ev));
	fbc_sync u_sync_start (.clock(clock), .srst(srst), .din(start_btn), .dout(start_lvl), .rise(start_ev));
	fbc_sync u_sync_stop (.clock(clock), .srst(srst), .din(stop_btn), .dout(stop_lvl), .rise(stop_ev));
	fbc_sync u_sync_flow (.clock(clock), .srst(srst), .din(flow_pulse), .dout(flow_lvl), .rise(flow_ev));
	fbc_sync u_sync_rev (.clock(clock), .srst(srst), .din(flow_rev), .dout(rev_lvl), .rise());

	// ----------------------------------------
	// Flow alarms.
	// ----------------------------------------
	fbc_alarm u_alarm1 (
		.clock(clock),
		.srst(srst),
		.enable(~batch_en), // [R03] [R04]
		.flow_pct(flow_pct),
		.setpoint(alarm_sp1),
		.active(alarm1) // [R05]
	);

	fbc_alarm u_alarm2 (
		.clock(clock),
		.srst(srst),
		.enable(~batch_en), // [R03] [R04]
		.flow_pct(flow_pct),
		.setpoint(alarm_sp2),
		.active(alarm2) // [R05]
	);

	// ----------------------------------------
	// APB decode.
	// ----------------------------------------
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `FBC_OFF_SCALED);
	assign pslverr = psel & penable & ~mapped;
	assign size_wr_ok = ~edit_lock | setup_unlocked; // [R01] [R02]
	assign alarm_wr_ok = ~batch_en & (~edit_lock | setup_unlocked); // [R04]

	always @* begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`FBC_OFF_CTRL: rd_mux = {27'h0, count_up, count_mode, batch_en, edit_lock};
			`FBC_OFF_SIZE: rd_mux[BW-1:0] = batch_size;
			`FBC_OFF_PREWARN: rd_mux[BW-1:0] = prewarn_level;
			`FBC_OFF_ALARM: rd_mux = {17'h0, alarm_sp2, 1'b0, alarm_sp1};
			`FBC_OFF_UNITS: rd_mux = {unit_abbr, 4'h0, total_units};
			`FBC_OFF_CONV: rd_mux = conv_factor;
			`FBC_OFF_GRAND: rd_mux[TW-1:0] = grand_total;
			`FBC_OFF_COUNT: rd_mux[TW-1:0] = forward_counter;
			`FBC_OFF_RCOUNT: rd_mux[TW-1:0] = reverse_counter;
			`FBC_OFF_BATCH: rd_mux[BW-1:0] = disp_batch;
			`FBC_OFF_STATUS: rd_mux = {20'h0, alarm2, alarm1, relay2, relay1, relay2_cmd, relay1_cmd, 1'b0, state};
			`FBC_OFF_INT_STAT: rd_mux = {28'h0, int_stat};
			`FBC_OFF_INT_MASK: rd_mux = {28'h0, int_mask};
			`FBC_OFF_SCALED: rd_mux[TW-1:0] = scaled_total;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always @(posedge clock) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rd_mux;
		end
	end

	// ----------------------------------------
	// Configuration registers.
	// ----------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			{count_up, count_mode, batch_en, edit_lock} <= `FBC_RST_CTRL;
			batch_size <= {BW{1'b0}};
			prewarn_level <= {BW{1'b0}};
			alarm_sp1 <= 7'h00;
			alarm_sp2 <= 7'h00;
			total_units <= 4'h0;
			unit_abbr <= 24'h000000;
			conv_factor <= `FBC_RST_CONV;
			int_mask <= 4'h0;
		end else if (wr_en) begin
			case (paddr)
				`FBC_OFF_CTRL: begin
					edit_lock <= pwdata[`FBC_CTRL_LOCK];
					batch_en <= pwdata[`FBC_CTRL_BATCH]; // [R03]
					if (pwdata[`FBC_CTRL_MODE_HI:`FBC_CTRL_MODE_LO] <= `FBC_MODE_NET) begin
						count_mode <= pwdata[`FBC_CTRL_MODE_HI:`FBC_CTRL_MODE_LO]; // [R06]
					end
					count_up <= pwdata[`FBC_CTRL_UP]; // [R10]
				end
				`FBC_OFF_SIZE: begin
					if (size_wr_ok) begin
						batch_size <= pwdata[BW-1:0]; // [R01] [R02]
					end
				end
				`FBC_OFF_PREWARN: begin
					if (size_wr_ok) begin
						prewarn_level <= pwdata[BW-1:0]; // [R01] [R02]
					end
				end
				`FBC_OFF_ALARM: begin
					if (alarm_wr_ok && pwdata[6:0] <= `FBC_PCT_MAX &&
						pwdata[`FBC_ALARM2_HI:`FBC_ALARM2_LO] <= `FBC_PCT_MAX) begin
						alarm_sp1 <= pwdata[6:0]; // [R04] [R05]
						alarm_sp2 <= pwdata[`FBC_ALARM2_HI:`FBC_ALARM2_LO];
					end
				end
				`FBC_OFF_UNITS: begin
					if (pwdata[3:0] <= `FBC_UNIT_LAST || pwdata[3:0] == `FBC_UNIT_USER) begin
						total_units <= pwdata[3:0]; // [R07]
						unit_abbr <= pwdata[`FBC_UNIT_ABBR_HI:`FBC_UNIT_ABBR_LO];
					end
				end
				`FBC_OFF_CONV: conv_factor <= pwdata; // [R08]
				`FBC_OFF_INT_MASK: int_mask <= pwdata[3:0];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Batch sequencer.
	// ----------------------------------------
	assign running = (state == ST_RUN) || (state == ST_PRE);
	assign qualified = running & flow_ev & ~rev_lvl; // [R16] [R19]
	assign prewarn_hit = (state == ST_RUN) && qualified && (batch_cnt + 1'b1 >= prewarn_level);
	assign done_hit = running && qualified && (batch_cnt + 1'b1 == batch_size); // [R19]

	always @* begin
		next_state = state;
		case (state)
			ST_READY: begin
				if (start_ev) next_state = ST_RUN; // [R13]
			end
			ST_RUN: begin
				if (rearm_ev) next_state = ST_READY;
				else if (stop_ev) next_state = ST_STOP; // [R16]
				else if (done_hit) next_state = ST_HOLD; // [R15]
				else if (prewarn_hit) next_state = ST_PRE; // [R14]
			end
			ST_PRE: begin
				if (rearm_ev) next_state = ST_READY;
				else if (stop_ev) next_state = ST_STOP; // [R16]
				else if (done_hit) next_state = ST_HOLD; // [R15]
			end
			ST_HOLD: begin
				if (rearm_ev) next_state = ST_READY; // [R12]
			end
			ST_STOP: begin
				if (rearm_ev) next_state = ST_READY; // [R17]
				else if (start_ev && relay2_cmd) next_state = ST_RUN; // [R17]
				else if (start_ev) next_state = ST_PRE; // [R17]
			end
			default: next_state = ST_HOLD;
		endcase
		if (!batch_en) next_state = ST_HOLD;
	end

	always @(posedge clock) begin
		if (srst) begin
			state <= ST_HOLD;
			relay1_cmd <= 1'b0;
			relay2_cmd <= 1'b0;
			batch_cnt <= {BW{1'b0}};
		end else begin
			state <= next_state;
			if (next_state == ST_READY) begin
				batch_cnt <= {BW{1'b0}}; // [R12]
				relay1_cmd <= 1'b0;
				relay2_cmd <= 1'b0;
			end else if (next_state == ST_HOLD) begin
				relay1_cmd <= 1'b0; // [R15]
				relay2_cmd <= 1'b0;
				if (qualified) batch_cnt <= batch_cnt + 1'b1;
			end else begin
				if (state == ST_READY && next_state == ST_RUN) begin
					relay1_cmd <= 1'b1; // [R13]
					relay2_cmd <= 1'b1;
				end
				if (next_state == ST_PRE) relay2_cmd <= 1'b0; // [R14]
				if (qualified) batch_cnt <= batch_cnt + 1'b1; // [R19]
			end
		end
	end

	assign relay1 = relay1_cmd & (state != ST_STOP); // [R10] [R16]
	assign relay2 = relay2_cmd & (state != ST_STOP); // [R10] [R16]

	// ----------------------------------------
	// Totals.
	// ----------------------------------------
	assign scale_prod = {32'h0, forward_counter} * {30'h0, conv_factor};

	always @(posedge clock) begin
		if (srst) begin
			grand_total <= {TW{1'b0}};
			forward_counter <= {TW{1'b0}};
			reverse_counter <= {TW{1'b0}};
			scaled_total <= {TW{1'b0}};
		end else begin
			scaled_total <= scale_prod[TW+`FBC_CONV_FRAC-1:`FBC_CONV_FRAC]; // [R08]
			if (wr_en && paddr == `FBC_OFF_PRESET) begin
				if (batch_en) grand_total <= pwdata[TW-1:0]; // [R09]
				else forward_counter <= pwdata[TW-1:0]; // [R09]
			end else begin
				if (qualified) grand_total <= grand_total + 1'b1; // [R18]
				if (flow_ev && !batch_en) begin
					if (!rev_lvl) forward_counter <= forward_counter + 1'b1; // [R06]
					else if (count_mode == `FBC_MODE_NET) forward_counter <= forward_counter - 1'b1; // [R06]
					else if (count_mode == `FBC_MODE_FWDREV) reverse_counter <= reverse_counter + 1'b1; // [R06]
				end
			end
		end
	end

	// ----------------------------------------
	// Status display.
	// ----------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			alt_cnt <= 32'h0000_0000;
			alt_tick <= 1'b0;
		end else begin
			alt_tick <= 1'b0;
			if (alt_cnt >= ALT_LAST) begin
				alt_cnt <= 32'h0000_0000;
				alt_tick <= 1'b1;
			end else begin
				alt_cnt <= alt_cnt + 32'h0000_0001;
			end
		end
	end

	always @(posedge clock) begin
		if (srst) begin
			disp_digit1 <= 1'b0;
			disp_digit2 <= 1'b0;
			disp_show_batch <= 1'b0;
			disp_state <= ST_HOLD;
			disp_batch <= {BW{1'b0}};
		end else begin
			disp_digit1 <= relay1_cmd; // [R11] [R16]
			disp_digit2 <= relay2_cmd; // [R11] [R16]
			disp_state <= state;
			disp_batch <= count_up ? batch_cnt : batch_size - batch_cnt; // [R10]
			if (state != ST_HOLD) disp_show_batch <= 1'b1; // [R12]
			else if (alt_tick) disp_show_batch <= ~disp_show_batch; // [R15]
		end
	end

	// ----------------------------------------
	// Interrupts.
	// ----------------------------------------
	assign events = {stop_ev & running, done_hit, prewarn_hit, start_ev & (state == ST_READY || state == ST_STOP)};

	always @(posedge clock) begin
		if (srst) begin
			int_stat <= 4'h0;
		end else if (wr_en && paddr == `FBC_OFF_INT_STAT) begin
			int_stat <= (int_stat & ~pwdata[3:0]) | events;
		end else begin
			int_stat <= int_stat | events;
		end
	end

	assign irq = |(int_stat & int_mask);

endmodule

// File: inc/fbc_consts.vh
`ifndef FBC_CONSTS_VH
`define FBC_CONSTS_VH

// ----------------------------------------
// Register byte offsets.
// ----------------------------------------
`define FBC_OFF_CTRL 8'h00
`define FBC_OFF_SIZE 8'h04
`define FBC_OFF_PREWARN 8'h08
`define FBC_OFF_ALARM 8'h0c
`define FBC_OFF_UNITS 8'h10
`define FBC_OFF_CONV 8'h14
`define FBC_OFF_PRESET 8'h18
`define FBC_OFF_GRAND 8'h1c
`define FBC_OFF_COUNT 8'h20
`define FBC_OFF_RCOUNT 8'h24
`define FBC_OFF_BATCH 8'h28
`define FBC_OFF_STATUS 8'h2c
`define FBC_OFF_INT_STAT 8'h30
`define FBC_OFF_INT_MASK 8'h34
`define FBC_OFF_SCALED 8'h38

// ----------------------------------------
// Field positions.
// ----------------------------------------
`define FBC_CTRL_LOCK 0
`define FBC_CTRL_BATCH 1
`define FBC_CTRL_MODE_LO 2
`define FBC_CTRL_MODE_HI 3
`define FBC_CTRL_UP 4
`define FBC_ALARM2_LO 8
`define FBC_ALARM2_HI 14
`define FBC_UNIT_ABBR_LO 8
`define FBC_UNIT_ABBR_HI 31

// ----------------------------------------
// Count modes and unit codes.
// ----------------------------------------
`define FBC_MODE_FWD 2'h0
`define FBC_MODE_FWDREV 2'h1
`define FBC_MODE_NET 2'h2
`define FBC_UNIT_LAST 4'h3
`define FBC_UNIT_USER 4'hf

// ----------------------------------------
// Reset values and limits.
// ----------------------------------------
`define FBC_RST_CTRL 5'h01
`define FBC_RST_CONV 32'h0001_0000
`define FBC_CONV_FRAC 16
`define FBC_PCT_MAX 7'h63
`define FBC_ALT_TIME_MS 1000
`define FBC_CLK_KHZ 40000

`endif

// File: rtl/fbc_sync.v
module fbc_sync (
	input wire clock,
	input wire srst,
	input wire din,
	output reg dout,
	output reg rise
);

	reg ff1;
	reg ff2;
	reg ff3;

	// ----------------------------------------
	// Three stages; a change counts once the last two agree.
	// ----------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			ff1 <= 1'b0;
			ff2 <= 1'b0;
			ff3 <= 1'b0;
			dout <= 1'b0;
			rise <= 1'b0;
		end else begin
			ff1 <= din;
			ff2 <= ff1;
			ff3 <= ff2;
			rise <= 1'b0;
			if (ff2 == ff3) begin
				dout <= ff3;
				rise <= ff3 & ~dout;
			end
		end
	end

endmodule

// File: rtl/fbc_alarm.v
module fbc_alarm (
	input wire clock,
	input wire srst,
	input wire enable,
	input wire [6:0] flow_pct,
	input wire [6:0] setpoint,
	output reg active
);

	// ----------------------------------------
	// Contact closes once flow reaches the setpoint.
	// ----------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			active <= 1'b0;
		end else begin
			active <= enable & (flow_pct >= setpoint);
		end
	end

endmodule

// File: dv/fbc_sva.sv
module fbc_sva (
	input wire clock,
	input wire srst,
	input wire relay1,
	input wire relay2,
	input wire alarm1,
	input wire alarm2,
	input wire disp_digit1,
	input wire disp_digit2,
	input wire disp_show_batch,
	input wire [4:0] disp_state
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	// ----------------------------------------
	// Relay, state, digit, alarm and display toggle checks.
	// ----------------------------------------
	sequence s_launch;
		$rose(relay1) && relay2;
	endsequence
	sequence s_prewarn;
		$fell(relay2) && relay1;
	endsequence
	a_start_run: assert property (s_launch |=> disp_state == 5'h02) else $error("start without run");
	a_prewarn_drop: assert property (s_prewarn |=> disp_state == 5'h04) else $error("relay two drop");
	a_hold_relays: assert property (disp_state == 5'h08 |-> !relay1 && !relay2) else $error("relay on in hold");
	a_stop_relays: assert property (disp_state == 5'h10 |-> !$past(relay1) && !$past(relay2))
		else $error("relay on in stop");
	a_stop_digit: assert property (disp_state == 5'h10 |-> disp_digit1) else $error("digit one off in stop");
	a_digit_one: assert property (relay1 |=> disp_digit1) else $error("digit one missing");
	a_digit_two: assert property (relay2 |=> disp_digit2) else $error("digit two missing");
	a_alarm_batch: assert property (disp_state != 5'h08 |-> !alarm1 && !alarm2) else $error("alarm in batch");
	a_state_onehot: assert property ($onehot(disp_state)) else $error("state not one-hot");
	a_alt_hold: assert property ($changed(disp_show_batch) |-> disp_state == 5'h08 || $past(disp_state) == 5'h08)
		else $error("toggle outside hold");
endmodule
bind fbc_top fbc_sva u_sva (.clock(clock), .srst(srst), .relay1(relay1), .relay2(relay2), .alarm1(alarm1),
	.alarm2(alarm2), .disp_digit1(disp_digit1), .disp_digit2(disp_digit2), .disp_show_batch(disp_show_batch),
	.disp_state(disp_state));

// File: dv/fbc_partner.sv
module fbc_partner (
	input wire clock,
	output logic rearm_btn,
	output logic start_btn,
	output logic stop_btn,
	output logic flow_pulse,
	output logic flow_rev
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{rearm_btn, start_btn, stop_btn, flow_pulse, flow_rev} = 5'h00;
	end
	// Pushes one operator button: 0 rearm, 1 start, 2 stop.
	task press(input int k);
		if (k == 0) rearm_btn <= 1'b1;
		else if (k == 1) start_btn <= 1'b1;
		else stop_btn <= 1'b1;
		repeat (6) @(posedge clock);
		{rearm_btn, start_btn, stop_btn} <= 3'h0;
		repeat (6) @(posedge clock);
	endtask
	// Delivers n registration units of flow in the given direction.
	task pulse(input int n, input logic rev);
		flow_rev <= rev;
		repeat (4) @(posedge clock);
		repeat (n) begin
			flow_pulse <= 1'b1;
			repeat (4) @(posedge clock);
			flow_pulse <= 1'b0;
			repeat (4) @(posedge clock);
		end
	endtask
endmodule

// File: dv/tb_flow_batch_controller.sv
`include "fbc_consts.vh"
module tb_flow_batch_controller;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, setup_unlocked = 0, qe, c1, c2;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, q;
	logic [6:0] flow_pct = 7'h00;
	logic [4:0] st;
	wire [31:0] prdata;
	wire [19:0] disp_batch;
	wire [4:0] disp_state;
	wire pready, pslverr, rearm_btn, start_btn, stop_btn, flow_pulse, flow_rev;
	wire relay1, relay2, alarm1, alarm2, disp_digit1, disp_digit2, disp_show_batch, irq;
	int error_cnt = 0, n_checks = 0, cnt, size, pw, g, i, m, p;
	always #12.5 clock = ~clock;
	fbc_top #(.ALT_CYCLES(8)) dut (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rearm_btn, .start_btn, .stop_btn, .flow_pulse, .flow_rev, .flow_pct, .setup_unlocked, .relay1,
		.relay2, .alarm1, .alarm2, .disp_digit1, .disp_digit2, .disp_show_batch, .disp_state, .disp_batch, .irq);
	fbc_partner u_op (.clock, .rearm_btn, .start_btn, .stop_btn, .flow_pulse, .flow_rev);
	// ----------------------------------------
	// Checking and bus tasks.
	// ----------------------------------------
	task complete_run;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		qe = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task pins;
		chk({disp_state, relay1, relay2, disp_digit1, disp_digit2}, {st, c1 && st != 5'h10, c2 && st != 5'h10, c1, c2});
	endtask
	// Operator push with the reference state update.
	task btn(input int k);
		u_op.press(k);
		if (k == 0) begin
			st = 5'h01;
			cnt = 0;
			{c1, c2} = 2'h0;
		end else if (k == 1 && (st == 5'h01 || st == 5'h10)) begin
			if (st == 5'h01) {c1, c2} = 2'h3;
			st = c2 ? 5'h02 : 5'h04;
		end else if (k == 2 && (st == 5'h02 || st == 5'h04)) st = 5'h10;
	endtask
	// One unit of forward flow with the reference count update.
	task fl;
		u_op.pulse(1, 1'b0);
		if (st == 5'h02 || st == 5'h04) begin
			cnt++;
			g++;
			if (cnt >= pw) {st, c2} = {5'h04, 1'b0};
			if (cnt == size) {st, c1} = {5'h08, 1'b0};
		end
		pins;
		chk(disp_batch, cnt);
	endtask
	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	initial begin
		void'($urandom(94));
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		{st, c1, c2} = {5'h08, 2'h0};
		@(posedge clock);
		pins;
		rdc(`FBC_OFF_CTRL, 32'h1);
		apb(1'b0, 8'h3c, 32'h0);
		chk(qe, 1'b1);
		chk(q, 32'h0);
		apb(1'b0, `FBC_OFF_SIZE, 32'h0);
		p = q;
		apb(1'b1, `FBC_OFF_SIZE, p + 3);
		rdc(`FBC_OFF_SIZE, p);
		setup_unlocked <= 1'b1;
		apb(1'b1, `FBC_OFF_SIZE, 32'h9);
		rdc(`FBC_OFF_SIZE, 32'h9);
		apb(1'b1, `FBC_OFF_CTRL, 32'h0);
		setup_unlocked <= 1'b0;
		apb(1'b1, `FBC_OFF_PREWARN, 32'h4);
		rdc(`FBC_OFF_PREWARN, 32'h4);
		m = $urandom % 100;
		flow_pct <= 7'($urandom % 100);
		apb(1'b1, `FBC_OFF_ALARM, 32'h3200 | m);
		repeat (4) @(posedge clock);
		chk({alarm1, alarm2}, {flow_pct >= m, flow_pct >= 7'd50});
		for (m = 0; m < 3; m++) begin
			apb(1'b1, `FBC_OFF_CTRL, m << 2);
			p = $urandom % 1000;
			apb(1'b1, `FBC_OFF_PRESET, p);
			u_op.pulse(2, 1'b0);
			u_op.pulse(1, 1'b1);
			rdc(`FBC_OFF_COUNT, p + (m == 2 ? 1 : 2));
			rdc(`FBC_OFF_RCOUNT, m > 0);
		end
		apb(1'b1, `FBC_OFF_CONV, 32'h0001_4000);
		rdc(`FBC_OFF_SCALED, (p + 1) * 5 / 4);
		apb(1'b1, `FBC_OFF_UNITS, 32'h4142_4305);
		rdc(`FBC_OFF_UNITS, 32'h0);
		apb(1'b1, `FBC_OFF_UNITS, 32'h4142_430f);
		rdc(`FBC_OFF_UNITS, 32'h4142_430f);
		apb(1'b1, `FBC_OFF_CTRL, 32'h12);
		repeat (4) @(posedge clock);
		chk({alarm1, alarm2}, 0);
		g = $urandom % 1000;
		apb(1'b1, `FBC_OFF_PRESET, g);
		size = 5 + $urandom % 3;
		pw = 2 + $urandom % 2;
		apb(1'b1, `FBC_OFF_SIZE, size);
		apb(1'b1, `FBC_OFF_PREWARN, pw);
		apb(1'b1, `FBC_OFF_INT_MASK, 32'h0);
		btn(0);
		pins;
		btn(1);
		pins;
		while (cnt <= pw) fl;
		btn(2);
		pins;
		rdc(`FBC_OFF_GRAND, g);
		u_op.pulse(1, 1'b0);
		rdc(`FBC_OFF_BATCH, cnt);
		btn(1);
		pins;
		while (st != 5'h08) fl;
		chk(irq, 1'b0);
		apb(1'b1, `FBC_OFF_INT_MASK, 32'h4);
		chk(irq, 1'b1);
		apb(1'b1, `FBC_OFF_INT_STAT, 32'h4);
		chk(irq, 1'b0);
		p = disp_show_batch;
		i = 0;
		while (disp_show_batch === p && i < 20) begin
			@(posedge clock);
			i++;
		end
		chk(i < 20, 1'b1);
		btn(0);
		pins;
		p = disp_show_batch;
		repeat (20) @(posedge clock);
		chk(disp_show_batch, p);
		btn(1);
		btn(2);
		btn(0);
		pins;
		rdc(`FBC_OFF_BATCH, 32'h0);
		apb(1'b1, `FBC_OFF_CTRL, 32'h2);
		rdc(`FBC_OFF_BATCH, size);
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		complete_run;
	end
endmodule
